// File: design/fan_pkg.sv
// Purpose: shared constants and types for the fan routing mux and start-temperature loop
// Assumes: 8-bit temperatures and duties, three channels, three fan outputs
// Notes:   register offsets are byte addresses on the 8-bit register port
package fan_pkg;
	localparam int NCH  = 3;
	localparam int NOUT = 3;
	localparam int NFLG = 6;

	// channel indices
	localparam int CH_REMOTE1 = 0;
	localparam int CH_LOCAL   = 1;
	localparam int CH_REMOTE2 = 2;

	// register offsets, element i belongs to channel or output i
	localparam logic [NOUT-1:0][7:0] ADDR_DUTY   = {8'h32, 8'h31, 8'h30};
	localparam logic [NCH-1:0][7:0]  ADDR_TARGET = {8'h35, 8'h34, 8'h33};
	localparam logic [NOUT-1:0][7:0] ADDR_CFG    = {8'h5e, 8'h5d, 8'h5c};

	// reset values
	localparam logic [7:0] TARGET_RST = 8'ha4;
	localparam logic [7:0] START_RST  = 8'h9a;
	localparam logic [7:0] CFG_RST    = 8'h80;
	localparam logic [7:0] DUTY_OFF   = 8'h00;
	localparam logic [7:0] DUTY_FULL  = 8'hff;
	localparam logic [7:0] TEMP_MIN   = 8'h00;
	localparam logic [7:0] TEMP_MAX   = 8'hff;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// behaviour field position in the output config register
	localparam int BEHAVIOUR_MSB = 7;
	localparam int BEHAVIOUR_LSB = 5;

	// status flag layout: low-limit flags then high-limit flags
	localparam int FLG_LOW  = 0;
	localparam int FLG_HIGH = 3;

	// start-temperature adjust interval
	localparam int ADJUST_PERIOD_US = 1000;
	localparam int CLK_MHZ          = 125;
	localparam int ADJUST_CYCLES    = ADJUST_PERIOD_US * CLK_MHZ;

	typedef enum logic [2:0] {
		BH_REMOTE1  = 3'h0,
		BH_LOCAL    = 3'h1,
		BH_REMOTE2  = 3'h2,
		BH_FULL     = 3'h3,
		BH_OFF      = 3'h4,
		BH_FAST_LR2 = 3'h5,
		BH_FAST_ALL = 3'h6,
		BH_MANUAL   = 3'h7
	} behaviour_t;

	typedef struct packed {
		logic [7:0] lowLimit;
		logic [7:0] highLimit;
		logic [7:0] critLimit;
		logic [7:0] hyst;
		logic [2:0] slope;
	} chan_cfg_t;

	typedef struct packed {
		logic       fanOn;
		logic       critical;
		logic       lowNow;
		logic       highNow;
		logic [7:0] excess;
		logic [7:0] startTemp;
	} chan_stat_t;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage : fan_pkg

// File: design/channel_loop.sv
// Purpose: per-channel fan switching and excess tracking with dynamic fan start temperature
// Assumes: temperature comes from logic on ref_clk, adjustTick is a one-cycle pulse
// Notes:   start temperature walks one degree per tick toward holding the target
`timescale 1ns/1ps
module channel_loop (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [7:0]       temperature,
	input  wire logic [7:0]       target,
	input  wire fan_pkg::chan_cfg_t cfg,
	input  wire logic             dynEnable,
	input  wire logic             adjustTick,
	output fan_pkg::chan_stat_t   stat
);
	logic [7:0] startTemp_ff;
	logic       fanOn_ff;
	logic [7:0] excess_ff;
	logic       aboveStart;
	logic       belowOff;

	assign aboveStart = temperature > startTemp_ff;
	assign belowOff   = ({1'b0, temperature} + {1'b0, cfg.hyst}) < {1'b0, startTemp_ff};

	// hot zone lowers start, cool zone raises it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			startTemp_ff <= fan_pkg::START_RST;
		end else if (adjustTick && dynEnable) begin
			if (temperature > target && startTemp_ff != fan_pkg::TEMP_MIN) begin
				startTemp_ff <= startTemp_ff - 8'h01;
			end else if (temperature < target && startTemp_ff != fan_pkg::TEMP_MAX) begin
				startTemp_ff <= startTemp_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fanOn_ff <= 1'b0;
		end else if (aboveStart) begin
			fanOn_ff <= 1'b1;
		end else if (belowOff) begin
			fanOn_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			excess_ff <= fan_pkg::DUTY_OFF;
		end else begin
			excess_ff <= aboveStart ? temperature - startTemp_ff : fan_pkg::DUTY_OFF;
		end
	end

	assign stat.fanOn     = fanOn_ff;
	assign stat.critical  = temperature > cfg.critLimit;
	assign stat.lowNow    = temperature < cfg.lowLimit;
	assign stat.highNow   = temperature > cfg.highLimit;
	assign stat.excess    = excess_ff;
	assign stat.startTemp = startTemp_ff;

	a_start_lowers: assert property (@(posedge ref_clk) disable iff (!rst_n)
		adjustTick && dynEnable && temperature > target && startTemp_ff != 8'h00
		|=> startTemp_ff == $past(startTemp_ff) - 8'h01)
		else $error("start temperature did not step down");
	a_start_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(adjustTick && dynEnable) |=> $stable(startTemp_ff))
		else $error("start temperature moved without a tick");
	a_fan_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
		temperature > startTemp_ff |=> fanOn_ff)
		else $error("fan not switched on above start");
	a_fan_off_hyst: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(fanOn_ff) |-> $past(belowOff))
		else $error("fan switched off inside hysteresis band");
	c_start_moves: cover property (@(posedge ref_clk) disable iff (!rst_n)
		adjustTick && dynEnable ##1 $changed(startTemp_ff));
endmodule : channel_loop

// File: design/fan_control_mux.sv
// Purpose: temperature-to-fan routing mux with dynamic start-temperature control
// Assumes: register port and temperatures are synchronous to ref_clk
// Notes:   duty registers read back the duty being driven on each output
// Functional notes
// - three 8-bit zone target registers, one per channel, reset to 0xa4.
// - with dynamic control on, each channel's start temperature walks to hold its zone at target.
// - a temperature below its low limit sets a sticky flag and may raise the alert.
// - a temperature above its high limit sets a sticky flag and may raise the alert.
// - a temperature above its critical limit can drive the fans it controls at full duty.
// - in automatic mode a fan switches on once its channel passes the start temperature.
// - above start the duty rises with temperature by a per-channel slope.
// - each output has its own config register whose bits 7 to 5 select its behaviour.
// - behaviour 000, 001 and 010 pick remote 1, local or remote 2 as the single source.
// - behaviour 101 takes the fastest of local and remote 2, 110 the fastest of all three.
// - behaviour 011 runs the output at full speed.
// - behaviour 100 disables the output and is the reset default.
// - behaviour 111 makes the duty register writable and its value drives the output.
// - a fan switched on by its channel never runs below the output's minimum duty.
// - a fan switches off only below start temperature minus hysteresis.
`timescale 1ns/1ps
module fan_control_mux #(
	parameter int ADJUST_CYCLES = fan_pkg::ADJUST_CYCLES
) (
	input  wire logic                               ref_clk,
	input  wire logic                               rst_n,
	input  wire fan_pkg::reg_req_t                  regReq,
	output logic [7:0]                              regRdData,
	input  wire logic [fan_pkg::NCH-1:0][7:0]       temperature,
	input  wire fan_pkg::chan_cfg_t [fan_pkg::NCH-1:0] chanCfg,
	input  wire logic [fan_pkg::NOUT-1:0][7:0]      minDuty,
	input  wire logic                               dynEnable,
	input  wire logic                               critEnable,
	input  wire logic [fan_pkg::NFLG-1:0]           alertMask,
	input  wire logic [fan_pkg::NFLG-1:0]           statusClear,
	output logic [fan_pkg::NFLG-1:0]                statusFlags,
	output logic                                    alertReq,
	output logic [fan_pkg::NOUT-1:0][7:0]           fanDuty,
	output logic [fan_pkg::NOUT-1:0]                fanDrive
);
	localparam int CW = $clog2(ADJUST_CYCLES + 1);
	localparam logic [CW-1:0] TICK_LAST = CW'(ADJUST_CYCLES - 1);
	localparam logic [CW-1:0] TICK_ZERO = '0;

	logic [fan_pkg::NCH-1:0][7:0]  target_ff;
	logic [fan_pkg::NOUT-1:0][7:0] cfg_ff;
	logic [fan_pkg::NOUT-1:0][7:0] manualDuty_ff;
	logic [fan_pkg::NOUT-1:0][7:0] duty_ff;
	logic [fan_pkg::NOUT-1:0][7:0] nxt_duty;
	logic [fan_pkg::NFLG-1:0]      flags_ff;
	logic [fan_pkg::NFLG-1:0]      flagSet;
	logic [7:0]                    rdData_ff;
	logic [7:0]                    nxt_rdData;
	logic [7:0]                    pwmCnt_ff;
	logic [fan_pkg::NOUT-1:0]      drive_ff;
	logic [CW-1:0]                 tickCnt_ff;
	logic                          adjustTick;
	fan_pkg::chan_stat_t [fan_pkg::NCH-1:0] stat;
	fan_pkg::behaviour_t [fan_pkg::NOUT-1:0] behaviour;

	// behaviour field of each output config register
	always_comb begin
		for (int o = 0; o < fan_pkg::NOUT; o++) begin
			behaviour[o] = fan_pkg::behaviour_t'(
				cfg_ff[o][fan_pkg::BEHAVIOUR_MSB:fan_pkg::BEHAVIOUR_LSB]);
		end
	end

	// adjust interval for the start-temperature walk
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tickCnt_ff <= TICK_ZERO;
		end else begin
			tickCnt_ff <= (tickCnt_ff == TICK_LAST) ? TICK_ZERO : tickCnt_ff + CW'(1);
		end
	end
	assign adjustTick = (tickCnt_ff == TICK_LAST);

	generate
		for (genvar c = 0; c < fan_pkg::NCH; c++) begin : g_chan
			channel_loop u_loop (
				.ref_clk    (ref_clk),
				.rst_n      (rst_n),
				.temperature(temperature[c]),
				.target     (target_ff[c]),
				.cfg        (chanCfg[c]),
				.dynEnable  (dynEnable),
				.adjustTick (adjustTick),
				.stat       (stat[c])
			);
		end
	endgenerate

	// register writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_ff <= {fan_pkg::NCH{fan_pkg::TARGET_RST}};
			cfg_ff    <= {fan_pkg::NOUT{fan_pkg::CFG_RST}};
		end else if (regReq.write) begin
			for (int i = 0; i < fan_pkg::NCH; i++) begin
				if (regReq.addr == fan_pkg::ADDR_TARGET[i]) begin
					target_ff[i] <= regReq.wdata;
				end
			end
			for (int o = 0; o < fan_pkg::NOUT; o++) begin
				if (regReq.addr == fan_pkg::ADDR_CFG[o]) begin
					cfg_ff[o] <= regReq.wdata;
				end
			end
		end
	end

	// duty writes land only in manual mode
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			manualDuty_ff <= {fan_pkg::NOUT{fan_pkg::DUTY_OFF}};
		end else begin
			for (int o = 0; o < fan_pkg::NOUT; o++) begin
				if (regReq.write && regReq.addr == fan_pkg::ADDR_DUTY[o]
				    && behaviour[o] == fan_pkg::BH_MANUAL) begin
					manualDuty_ff[o] <= regReq.wdata;
				end
			end
		end
	end

	// read data one cycle after the read strobe
	always_comb begin
		nxt_rdData = fan_pkg::RD_UNMAPPED;
		for (int o = 0; o < fan_pkg::NOUT; o++) begin
			if (regReq.addr == fan_pkg::ADDR_DUTY[o]) begin
				nxt_rdData = duty_ff[o];
			end
			if (regReq.addr == fan_pkg::ADDR_CFG[o]) begin
				nxt_rdData = cfg_ff[o];
			end
		end
		for (int i = 0; i < fan_pkg::NCH; i++) begin
			if (regReq.addr == fan_pkg::ADDR_TARGET[i]) begin
				nxt_rdData = target_ff[i];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_ff <= fan_pkg::RD_UNMAPPED;
		end else if (regReq.read) begin
			rdData_ff <= nxt_rdData;
		end
	end
	assign regRdData = rdData_ff;

	// one channel's duty as seen by one output
	function automatic logic [7:0] chanDuty(input fan_pkg::chan_stat_t st,
	                                        input logic [2:0] slope,
	                                        input logic [7:0] floorDuty,
	                                        input logic crit);
		logic [15:0] raw;
		raw = {8'h00, floorDuty} + ({8'h00, st.excess} << slope);
		if (crit && st.critical) begin
			chanDuty = fan_pkg::DUTY_FULL;
		end else if (!st.fanOn) begin
			chanDuty = fan_pkg::DUTY_OFF;
		end else if (raw > {8'h00, fan_pkg::DUTY_FULL}) begin
			chanDuty = fan_pkg::DUTY_FULL;
		end else begin
			chanDuty = raw[7:0];
		end
	endfunction : chanDuty

	// mux from channels to outputs
	always_comb begin
		logic [fan_pkg::NCH-1:0][7:0] cd;
		cd = '0;
		for (int o = 0; o < fan_pkg::NOUT; o++) begin
			for (int c = 0; c < fan_pkg::NCH; c++) begin
				cd[c] = chanDuty(stat[c], chanCfg[c].slope, minDuty[o], critEnable);
			end
			case (behaviour[o])
				fan_pkg::BH_REMOTE1: nxt_duty[o] = cd[fan_pkg::CH_REMOTE1];
				fan_pkg::BH_LOCAL:   nxt_duty[o] = cd[fan_pkg::CH_LOCAL];
				fan_pkg::BH_REMOTE2: nxt_duty[o] = cd[fan_pkg::CH_REMOTE2];
				fan_pkg::BH_FULL:    nxt_duty[o] = fan_pkg::DUTY_FULL;
				fan_pkg::BH_OFF:     nxt_duty[o] = fan_pkg::DUTY_OFF;
				fan_pkg::BH_FAST_LR2: begin
					nxt_duty[o] = (cd[fan_pkg::CH_LOCAL] > cd[fan_pkg::CH_REMOTE2]) ?
						cd[fan_pkg::CH_LOCAL] : cd[fan_pkg::CH_REMOTE2];
				end
				fan_pkg::BH_FAST_ALL: begin
					nxt_duty[o] = cd[fan_pkg::CH_REMOTE1];
					for (int c = 1; c < fan_pkg::NCH; c++) begin
						if (cd[c] > nxt_duty[o]) begin
							nxt_duty[o] = cd[c];
						end
					end
				end
				fan_pkg::BH_MANUAL:  nxt_duty[o] = manualDuty_ff[o];
				default:             nxt_duty[o] = fan_pkg::DUTY_OFF;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			duty_ff <= {fan_pkg::NOUT{fan_pkg::DUTY_OFF}};
		end else begin
			duty_ff <= nxt_duty;
		end
	end
	assign fanDuty = duty_ff;

	// pulse-width generator, full duty holds the pin high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmCnt_ff <= fan_pkg::DUTY_OFF;
		end else begin
			pwmCnt_ff <= pwmCnt_ff + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_ff <= '0;
		end else begin
			for (int o = 0; o < fan_pkg::NOUT; o++) begin
				drive_ff[o] <= (duty_ff[o] == fan_pkg::DUTY_FULL) || (pwmCnt_ff < duty_ff[o]);
			end
		end
	end
	assign fanDrive = drive_ff;

	// sticky limit flags, a new event beats a clear in the same cycle
	always_comb begin
		for (int c = 0; c < fan_pkg::NCH; c++) begin
			flagSet[fan_pkg::FLG_LOW + c]  = stat[c].lowNow;
			flagSet[fan_pkg::FLG_HIGH + c] = stat[c].highNow;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~statusClear) | flagSet;
		end
	end
	assign statusFlags = flags_ff;
	assign alertReq    = |(flags_ff & alertMask);

	a_target_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		regReq.write && regReq.addr == fan_pkg::ADDR_TARGET[0]
		|=> target_ff[0] == $past(regReq.wdata))
		else $error("zone target not written");
	a_low_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
		temperature[2] < chanCfg[2].lowLimit |=> statusFlags[fan_pkg::FLG_LOW + 2])
		else $error("low limit flag not set");
	a_high_alert: assert property (@(posedge ref_clk) disable iff (!rst_n)
		temperature[0] > chanCfg[0].highLimit
		|=> statusFlags[fan_pkg::FLG_HIGH] && (alertReq || !alertMask[fan_pkg::FLG_HIGH]))
		else $error("high limit flag or alert missing");
	a_crit_full: assert property (@(posedge ref_clk) disable iff (!rst_n)
		critEnable && stat[0].critical && behaviour[1] == fan_pkg::BH_REMOTE1
		|=> fanDuty[1] == fan_pkg::DUTY_FULL)
		else $error("critical channel not at full duty");
	a_full_speed: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[2] == fan_pkg::BH_FULL |=> fanDuty[2] == fan_pkg::DUTY_FULL ##1 fanDrive[2])
		else $error("full speed output not at full duty");
	a_disabled_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[2] == fan_pkg::BH_OFF |=> fanDuty[2] == 8'h00)
		else $error("disabled output not off");
	a_manual_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[0] == fan_pkg::BH_MANUAL && regReq.write && regReq.addr == 8'h30
		##1 behaviour[0] == fan_pkg::BH_MANUAL |=> fanDuty[0] == $past(regReq.wdata, 2))
		else $error("manual duty not driven");
	a_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[1] != fan_pkg::BH_MANUAL |=> $stable(manualDuty_ff[1]))
		else $error("duty write taken outside manual mode");
	// any channel with nonzero excess is on, so its duty is at least its excess
	a_fastest_max: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[1] == fan_pkg::BH_FAST_ALL
		|=> fanDuty[1] >= $past(stat[0].excess) && fanDuty[1] >= $past(stat[1].excess)
		&& fanDuty[1] >= $past(stat[2].excess))
		else $error("fastest mode below a channel demand");
	a_fan_off_duty: assert property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[1] == fan_pkg::BH_LOCAL && !stat[1].fanOn && !(critEnable && stat[1].critical)
		|=> fanDuty[1] == 8'h00)
		else $error("single source drives duty while its fan is off");
	c_fast_all: cover property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[1] == fan_pkg::BH_FAST_ALL && stat[2].fanOn);
	c_manual: cover property (@(posedge ref_clk) disable iff (!rst_n)
		behaviour[0] == fan_pkg::BH_MANUAL && regReq.write && regReq.addr == 8'h30);
	c_alert: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(alertReq));
endmodule : fan_control_mux

// File: testbench/fan_load_model.sv
// Purpose: fan load on one drive pin, measures high cycles per 256-cycle window
// Assumes: drive pin is a plain level output on ref_clk
// Notes:   any 256 consecutive cycles hold exactly duty high cycles, or all 256 at full duty 0xff
`timescale 1ns/1ps
module fan_load_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       drive,
	output logic      [8:0] highCount
);
	logic [7:0] windowCnt_ff;
	logic [8:0] accum_ff;
	logic [8:0] highCount_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			windowCnt_ff <= 8'h00;
			accum_ff     <= 9'h000;
			highCount_ff <= 9'h000;
		end else begin
			windowCnt_ff <= windowCnt_ff + 8'h01;
			if (windowCnt_ff == 8'hff) begin
				highCount_ff <= accum_ff + {8'h00, drive};
				accum_ff     <= 9'h000;
			end else begin
				accum_ff <= accum_ff + {8'h00, drive};
			end
		end
	end
	assign highCount = highCount_ff;
endmodule : fan_load_model

// File: testbench/tb_fan_control_mux.sv
// Purpose: self-checking bench for the fan routing mux and start-temperature loop
// Assumes: ADJUST_CYCLES set to 8, start temperature 0x9a after reset
// Notes:   register strobes last one cycle with an idle cycle between accesses
`timescale 1ns/1ps
module tb_fan_control_mux;
	logic                                      ref_clk;
	logic                                      rst_n;
	fan_pkg::reg_req_t                         regReq;
	logic [7:0]                                regRdData;
	logic [fan_pkg::NCH-1:0][7:0]              temperature;
	fan_pkg::chan_cfg_t [fan_pkg::NCH-1:0]     chanCfg;
	logic [fan_pkg::NOUT-1:0][7:0]             minDuty;
	logic                                      dynEnable;
	logic                                      critEnable;
	logic [fan_pkg::NFLG-1:0]                  alertMask;
	logic [fan_pkg::NFLG-1:0]                  statusClear;
	logic [fan_pkg::NFLG-1:0]                  statusFlags;
	logic                                      alertReq;
	logic [fan_pkg::NOUT-1:0][7:0]             fanDuty;
	logic [fan_pkg::NOUT-1:0]                  fanDrive;
	logic [fan_pkg::NOUT-1:0][8:0]             measured;
	int                                        err_count;
	int                                        tests_run;
	logic [7:0]                                rd;

	fan_control_mux #(.ADJUST_CYCLES(8)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
		.temperature(temperature), .chanCfg(chanCfg), .minDuty(minDuty),
		.dynEnable(dynEnable), .critEnable(critEnable), .alertMask(alertMask),
		.statusClear(statusClear), .statusFlags(statusFlags), .alertReq(alertReq),
		.fanDuty(fanDuty), .fanDrive(fanDrive));

	for (genvar g = 0; g < fan_pkg::NOUT; g++) begin : g_fan
		fan_load_model i_fan (.ref_clk(ref_clk), .rst_n(rst_n), .drive(fanDrive[g]),
			.highCount(measured[g]));
	end

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk);
		#1 regReq = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
		@(posedge ref_clk);
		#1 regReq.write = 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge ref_clk);
		#1 regReq = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge ref_clk);
		#1 regReq.read = 1'b0;
		data = regRdData;
	endtask : reg_read

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	initial begin
		#(8 * 20000);
		err_count++;
		complete_run();
	end

	initial begin
		err_count   = 0;
		tests_run   = 0;
		rst_n       = 1'b0;
		regReq      = '0;
		temperature = {3{8'h20}};
		for (int i = 0; i < 3; i++)
			chanCfg[i] = '{lowLimit: 8'h10, highLimit: 8'hc0, critLimit: 8'hf0,
				hyst: 8'h04, slope: 3'h1};
		minDuty     = {3{8'h40}};
		dynEnable   = 1'b0;
		critEnable  = 1'b0;
		alertMask   = 6'h00;
		statusClear = 6'h00;
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 3; i++) begin
			reg_read(fan_pkg::ADDR_TARGET[i], rd);
			check("target reset", rd, 8'ha4);
			reg_read(fan_pkg::ADDR_CFG[i], rd);
			check("config reset", rd, 8'h80);
			reg_read(fan_pkg::ADDR_DUTY[i], rd);
			check("duty reset", rd, 8'h00);
			check("disabled duty", fanDuty[i], 8'h00);
		end
		reg_read(8'h40, rd);
		check("unmapped read", rd, 8'h00);
		reg_write(fan_pkg::ADDR_TARGET[0], 8'h5b);
		reg_read(fan_pkg::ADDR_TARGET[0], rd);
		check("target write", rd, 8'h5b);
		reg_write(fan_pkg::ADDR_TARGET[0], 8'ha4);
		reg_write(fan_pkg::ADDR_DUTY[1], 8'h55);
		reg_read(fan_pkg::ADDR_DUTY[1], rd);
		check("duty write ignored", rd, 8'h00);
		// manual mode on output 1
		reg_write(fan_pkg::ADDR_CFG[0], 8'he0);
		reg_write(fan_pkg::ADDR_DUTY[0], 8'h40);
		settle(4);
		check("manual duty", fanDuty[0], 8'h40);
		reg_read(fan_pkg::ADDR_DUTY[0], rd);
		check("manual readback", rd, 8'h40);
		reg_read(fan_pkg::ADDR_CFG[0], rd);
		check("config readback", rd, 8'he0);
		settle(600);
		check("pin high cycles", measured[0], 9'h040);
		reg_write(fan_pkg::ADDR_CFG[2], 8'h60);
		settle(4);
		check("full speed", fanDuty[2], 8'hff);
		reg_read(fan_pkg::ADDR_DUTY[2], rd);
		check("full readback", rd, 8'hff);
		// single source: output 2 follows the selected channel only
		for (int ch = 0; ch < 3; ch++) begin
			temperature = {3{8'h20}};
			temperature[ch] = 8'h9a;
			reg_write(fan_pkg::ADDR_CFG[1], {ch[2:0], 5'h00});
			settle(4);
			check("at start off", fanDuty[1], 8'h00);
			temperature[ch] = 8'h9c;
			settle(4);
			check("single source", fanDuty[1], 8'h44);
			temperature[ch] = 8'h97;
			settle(4);
			check("hyst hold", fanDuty[1], 8'h40);
			temperature[ch] = 8'h95;
			settle(4);
			check("hyst off", fanDuty[1], 8'h00);
		end
		temperature = {8'h9e, 8'h9c, 8'ha0};
		reg_write(fan_pkg::ADDR_CFG[1], 8'ha0);
		settle(4);
		check("fastest local r2", fanDuty[1], 8'h48);
		reg_write(fan_pkg::ADDR_CFG[1], 8'hc0);
		settle(4);
		check("fastest all", fanDuty[1], 8'h4c);
		reg_write(fan_pkg::ADDR_CFG[1], 8'h00);
		chanCfg[0].critLimit = 8'hb0;
		temperature[0] = 8'hb1;
		critEnable = 1'b1;
		settle(4);
		check("critical full", fanDuty[1], 8'hff);
		critEnable = 1'b0;
		settle(4);
		check("slope duty", fanDuty[1], 8'h6e);
		// sticky limit flags and alert
		temperature = {3{8'h20}};
		statusClear = 6'h3f;
		settle(2);
		statusClear = 6'h00;
		temperature[2] = 8'h05;
		temperature[0] = 8'hc5;
		alertMask = 6'h0c;
		settle(3);
		check("flags set", statusFlags, 6'h0c);
		check("alert on", alertReq, 1'b1);
		temperature = {3{8'h20}};
		alertMask = 6'h00;
		settle(2);
		check("flags sticky", statusFlags, 6'h0c);
		check("alert masked", alertReq, 1'b0);
		statusClear = 6'h3f;
		settle(2);
		statusClear = 6'h00;
		check("flags cleared", statusFlags, 6'h00);
		// dynamic start: zone above target lowers start one per tick
		chanCfg[0].critLimit = 8'hf0;
		chanCfg[0].slope = 3'h0;
		minDuty[1] = 8'h00;
		temperature[0] = 8'ha8;
		settle(4);
		check("excess duty", fanDuty[1], 8'h0e);
		dynEnable = 1'b1;
		settle(80);
		check("start walked", (fanDuty[1] > 8'h14) && (fanDuty[1] < 8'h1a), 1'b1);
		settle(520);
		check("pin full high", measured[2], 9'h100);
		complete_run();
	end
endmodule : tb_fan_control_mux
